// [core/bco_breaker_ctrl.sv]
// Breaker command outputs, filtered position, counter and state events
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Accepted open request drives open pulse for the set pulse length.
// - Accepted close request drives close pulse for the set pulse length.
// - Close waiting on sync too long raises sync-switch start output.
// - Every breaker operation gives a 150 ms operation pulse.
// - Position change without own pulse, sync start or external command flags unintended.
// - Closed indication comes from filtered position inputs.
// - Open indication comes from filtered position inputs.
// - Counter adds one each time the operation pulse starts.
// - Counter-reset request clears the operation counter to zero, or sets it to one when the operation pulse starts in the same cycle.
// - State event raised with new state on every state change.
// - Command channel open or close value drives matching command.
// - State: 0 neither, 1 open only, 2 closed only, 3 both.
// - Pulse ends early on confirmed switching, never before 100 ms.
// - Command needs local/remote permit, matching enable, sync for close when sync check is used.
// - Block-operation input suppresses all commands.
module bco_breaker_ctrl (
    input  wire logic                   core_clk_i,
    input  wire logic                   nrst_i,
    // Settings, times in milliseconds
    input  wire logic [bco_pkg::MS_W-1:0] pulse_ms_i,
    input  wire logic [bco_pkg::MS_W-1:0] synchk_ms_i,
    input  wire logic [bco_pkg::MS_W-1:0] interm_ms_i,
    input  wire logic                   sync_check_used_i,
    // Command sources, same clock domain
    input  wire logic                   local_cmd_i,
    input  wire logic                   local_permit_i,
    input  wire logic                   remote_permit_i,
    input  wire logic                   operator_command_channel_i,
    input  wire logic                   operator_command_value_i,
    input  wire logic                   open_permit_i,
    input  wire logic                   close_permit_i,
    input  wire logic                   synchronism_ok_i,
    input  wire logic                   block_operation_i,
    input  wire logic                   counter_reset_i,
    // Pins from the breaker
    input  wire logic                   position_open_in_i,
    input  wire logic                   position_closed_in_i,
    input  wire logic                   external_command_seen_i,
    // Register port for interrupt status
    input  wire logic [1:0]             addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rdata_o,
    output logic                        irq_o,
    // Outputs
    output logic                        open_pulse_out_o,
    output logic                        close_pulse_out_o,
    output logic                        sync_switch_start_o,
    output logic                        operation_o,
    output logic                        unintended_operation_o,
    output logic                        closed_ind_o,
    output logic                        open_ind_o,
    output logic [bco_pkg::CNT_W-1:0]   op_count_o,
    output logic [1:0]                  state_o,
    output logic                        state_event_o
);
    // ===========================================================
    // Millisecond tick
    // ===========================================================
    logic [bco_pkg::TICK_W-1:0] tick_reg;
    wire  ms_tick = (tick_reg == bco_pkg::TICK_W'(bco_pkg::TICK_PER_MS - 1));

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || ms_tick) tick_reg <= '0;
        else tick_reg <= tick_reg + 1'b1;
    end

    // ===========================================================
    // Pin synchronisers: change accepted when stages two and three agree
    // ===========================================================
    logic [2:0] s1_reg, s2_reg, s3_reg, pin_reg;
    wire  [2:0] pins = {external_command_seen_i, position_closed_in_i,
                        position_open_in_i};
    wire  [2:0] pin_next;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pin
            assign pin_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g]
                                                           : pin_reg[g];
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            pin_reg <= '0;
        end else begin
            s1_reg  <= pins;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            pin_reg <= pin_next;
        end
    end

    wire pos_open   = pin_reg[0];
    wire pos_closed = pin_reg[1];
    wire ext_seen   = pin_reg[2];

    // ===========================================================
    // Raw state and filtered indication
    // ===========================================================
    wire [1:0] raw_state = {pos_closed, pos_open};
    logic [1:0] filt_reg;
    logic [1:0] prev_raw_reg;
    logic [bco_pkg::MS_W-1:0] interm_cnt_reg;

    // Intermediate/bad must persist before it is reported
    wire raw_stable_end = (raw_state == bco_pkg::BCO_ST_OPEN) ||
                          (raw_state == bco_pkg::BCO_ST_CLOSED);
    wire interm_expired = ms_tick && (interm_cnt_reg >= interm_ms_i);
    wire [1:0] filt_next =
        (raw_stable_end || interm_expired) ? raw_state : filt_reg;
    wire state_chg = (filt_next != filt_reg);

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            filt_reg       <= bco_pkg::BCO_ST_INTERM;
            prev_raw_reg   <= bco_pkg::BCO_ST_INTERM;
            interm_cnt_reg <= '0;
        end else begin
            filt_reg     <= filt_next;
            prev_raw_reg <= raw_state;
            if (raw_state != prev_raw_reg || raw_stable_end)
                interm_cnt_reg <= '0;
            else if (ms_tick && interm_cnt_reg != '1)
                interm_cnt_reg <= interm_cnt_reg + 1'b1;
        end
    end

    // Transition between the two end positions is one operation
    wire op_event = state_chg &&
        ((filt_reg == bco_pkg::BCO_ST_OPEN &&
          filt_next == bco_pkg::BCO_ST_CLOSED) ||
         (filt_reg == bco_pkg::BCO_ST_CLOSED &&
          filt_next == bco_pkg::BCO_ST_OPEN));

    // ===========================================================
    // Command acceptance
    // ===========================================================
    wire src_ok   = local_cmd_i ? local_permit_i : remote_permit_i;
    wire want_cls = operator_command_channel_i &&
                    operator_command_value_i;
    wire want_opn = operator_command_channel_i &&
                    !operator_command_value_i;
    wire acc_opn  = want_opn && src_ok && open_permit_i &&
                    !block_operation_i;
    wire acc_cls  = want_cls && src_ok && close_permit_i &&
                    !block_operation_i;

    // ===========================================================
    // Command sequencer
    // ===========================================================
    bco_pkg::bco_seq_e seq_reg, seq_next;
    logic                     dir_close_reg;
    logic [bco_pkg::MS_W-1:0] ms_cnt_reg;
    logic                     opn_reg, cls_reg, sw_reg;

    wire confirmed = dir_close_reg ? (raw_state == bco_pkg::BCO_ST_CLOSED)
                                   : (raw_state == bco_pkg::BCO_ST_OPEN);
    wire min_done  = (ms_cnt_reg >= bco_pkg::MS_W'(bco_pkg::MIN_PULSE_MS));
    wire pulse_end = (ms_tick && ms_cnt_reg + 1'b1 >= pulse_ms_i) ||
                     (confirmed && min_done);
    wire sync_to   = ms_tick && (ms_cnt_reg + 1'b1 >= synchk_ms_i);
    wire cls_go    = !sync_check_used_i || synchronism_ok_i;

    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            bco_pkg::BCO_SQ_IDLE: begin
                if (acc_opn) seq_next = bco_pkg::BCO_SQ_PULSE;
                else if (acc_cls)
                    seq_next = cls_go ? bco_pkg::BCO_SQ_PULSE
                                      : bco_pkg::BCO_SQ_SYNC;
            end
            bco_pkg::BCO_SQ_SYNC: begin
                if (block_operation_i) seq_next = bco_pkg::BCO_SQ_IDLE;
                else if (synchronism_ok_i) seq_next = bco_pkg::BCO_SQ_PULSE;
                else if (sync_to) seq_next = bco_pkg::BCO_SQ_IDLE;
            end
            bco_pkg::BCO_SQ_PULSE: begin
                if (pulse_end || block_operation_i)
                    seq_next = bco_pkg::BCO_SQ_IDLE;
            end
            default: seq_next = bco_pkg::BCO_SQ_IDLE;
        endcase
    end

    wire enter_pulse = (seq_next == bco_pkg::BCO_SQ_PULSE) &&
                       (seq_reg != bco_pkg::BCO_SQ_PULSE);
    wire in_pulse    = (seq_next == bco_pkg::BCO_SQ_PULSE);
    wire sw_fire     = (seq_reg == bco_pkg::BCO_SQ_SYNC) &&
                       !block_operation_i && !synchronism_ok_i && sync_to;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            seq_reg       <= bco_pkg::BCO_SQ_IDLE;
            dir_close_reg <= 1'b0;
            ms_cnt_reg    <= '0;
            opn_reg       <= 1'b0;
            cls_reg       <= 1'b0;
            sw_reg        <= 1'b0;
        end else begin
            seq_reg <= seq_next;
            if (seq_reg == bco_pkg::BCO_SQ_IDLE)
                dir_close_reg <= !acc_opn && acc_cls;
            if (seq_next != seq_reg) ms_cnt_reg <= '0;
            else if (ms_tick) ms_cnt_reg <= ms_cnt_reg + 1'b1;
            opn_reg <= in_pulse && (enter_pulse ? acc_opn
                                                : !dir_close_reg);
            cls_reg <= in_pulse && (enter_pulse ? !acc_opn
                                                : dir_close_reg);
            sw_reg  <= sw_fire;
        end
    end

    // ===========================================================
    // Operation pulse, counter, unintended flag, events
    // ===========================================================
    logic [bco_pkg::MS_W-1:0] op_ms_reg;
    logic                     oper_reg, unint_reg, seen_cmd_reg, evt_reg;
    logic [bco_pkg::CNT_W-1:0] cnt_reg;

    wire oper_done = ms_tick &&
        (op_ms_reg + 1'b1 >= bco_pkg::MS_W'(bco_pkg::OPER_MS));
    // Command evidence is held from the pulse until the breaker moves
    wire cmd_seen_next = (seen_cmd_reg || opn_reg || cls_reg || ext_seen ||
                          sw_reg) && !op_event;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            op_ms_reg    <= '0;
            oper_reg     <= 1'b0;
            cnt_reg      <= '0;
            unint_reg    <= 1'b0;
            seen_cmd_reg <= 1'b0;
            evt_reg      <= 1'b0;
        end else begin
            if (op_event) begin
                oper_reg  <= 1'b1;
                op_ms_reg <= '0;
            end else if (oper_reg) begin
                if (oper_done) oper_reg <= 1'b0;
                if (ms_tick) op_ms_reg <= op_ms_reg + 1'b1;
            end
            // Reset wins only when no operation pulse starts this cycle
            if (op_event && !oper_reg) cnt_reg <= counter_reset_i ?
                bco_pkg::CNT_W'(1) : cnt_reg + 1'b1;
            else if (counter_reset_i) cnt_reg <= '0;
            if (op_event)
                unint_reg <= !(seen_cmd_reg || ext_seen);
            else if (opn_reg || cls_reg) unint_reg <= 1'b0;
            seen_cmd_reg <= cmd_seen_next;
            evt_reg      <= state_chg;
        end
    end

    // ===========================================================
    // Interrupt status, enable, clear
    // ===========================================================
    localparam logic [1:0] A_STAT = 2'h0;
    localparam logic [1:0] A_EN   = 2'h1;
    localparam logic [1:0] A_CLR  = 2'h2;
    localparam logic [1:0] A_CNT  = 2'h3;

    logic [bco_pkg::IRQ_W-1:0] stat_reg, en_reg;
    logic [31:0]               rdata_reg;
    logic                      irq_reg;
    wire  [bco_pkg::IRQ_W-1:0] ev_vec = {sw_fire, op_event && !oper_reg,
                                         op_event &&
                                         !(seen_cmd_reg || ext_seen),
                                         state_chg};
    wire  [bco_pkg::IRQ_W-1:0] clr_vec = (wr_i && addr_i == A_CLR) ?
                                         wdata_i[bco_pkg::IRQ_W-1:0] : '0;
    // Set wins over a clear in the same cycle
    wire  [bco_pkg::IRQ_W-1:0] stat_next = (stat_reg & ~clr_vec) | ev_vec;
    wire  [31:0] rd_mux =
        (addr_i == A_STAT) ? {28'h0000000, stat_reg} :
        (addr_i == A_EN)   ? {28'h0000000, en_reg}   :
        (addr_i == A_CNT)  ? cnt_reg : 32'h00000000;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            stat_reg  <= '0;
            en_reg    <= '0;
            rdata_reg <= '0;
            irq_reg   <= 1'b0;
        end else begin
            stat_reg  <= stat_next;
            if (wr_i && addr_i == A_EN) en_reg <= wdata_i[bco_pkg::IRQ_W-1:0];
            rdata_reg <= rd_i ? rd_mux : 32'h00000000;
            irq_reg   <= |(stat_next & en_reg);
        end
    end

    // ===========================================================
    // Outputs
    // ===========================================================
    logic [1:0] state_out_reg;
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) state_out_reg <= bco_pkg::BCO_ST_INTERM;
        else state_out_reg <= filt_next;
    end

    assign open_pulse_out_o       = opn_reg;
    assign close_pulse_out_o      = cls_reg;
    assign sync_switch_start_o    = sw_reg;
    assign operation_o            = oper_reg;
    assign unintended_operation_o = unint_reg;
    assign closed_ind_o  = (state_out_reg == bco_pkg::BCO_ST_CLOSED);
    assign open_ind_o    = (state_out_reg == bco_pkg::BCO_ST_OPEN);
    assign op_count_o    = cnt_reg;
    assign state_o       = state_out_reg;
    assign state_event_o = evt_reg;
    assign rdata_o       = rdata_reg;
    assign irq_o         = irq_reg;
endmodule : bco_breaker_ctrl
`default_nettype wire

// [core/bco_pkg.sv]
// Package of constants for the breaker command output logic
package bco_pkg;
    // ===========================================================
    // Clock and timing
    // ===========================================================
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned TICK_PER_MS  = CLK_HZ / 1000;
    localparam int unsigned OPER_MS      = 150;
    localparam int unsigned MIN_PULSE_MS = 100;
    localparam int unsigned MS_W         = 16;
    localparam int unsigned TICK_W       = 18;
    localparam int unsigned CNT_W        = 32;

    // ===========================================================
    // Setting defaults, in milliseconds
    // ===========================================================
    localparam logic [15:0] PULSE_MS_RST   = 16'h012C;
    localparam logic [15:0] SYNCHK_MS_RST  = 16'h03E8;
    localparam logic [15:0] INTERM_MS_RST  = 16'h0064;

    // ===========================================================
    // Breaker state encoding
    // ===========================================================
    typedef enum logic [1:0] {
        BCO_ST_INTERM = 2'h0,
        BCO_ST_OPEN   = 2'h1,
        BCO_ST_CLOSED = 2'h2,
        BCO_ST_BAD    = 2'h3
    } bco_state_e;

    // ===========================================================
    // Command sequencer states, one bit flips from idle to sync and from sync to pulse
    // ===========================================================
    typedef enum logic [1:0] {
        BCO_SQ_IDLE  = 2'h0,
        BCO_SQ_SYNC  = 2'h1,
        BCO_SQ_PULSE = 2'h3
    } bco_seq_e;

    // ===========================================================
    // Interrupt status bit constants; the status register holds unintended at bit 1 and operation at bit 2
    // ===========================================================
    localparam int unsigned IRQ_STATE  = 0;
    localparam int unsigned IRQ_OPER   = 1;
    localparam int unsigned IRQ_UNINT  = 2;
    localparam int unsigned IRQ_SYNCSW = 3;
    localparam int unsigned IRQ_W      = 4;
endpackage : bco_pkg

// [sim/bco_breaker_ctrl_assertions.sv]
// Concurrent checks on the breaker command block ports
`timescale 1ns/10ps
`default_nettype none
module bco_breaker_ctrl_assertions (
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        sync_check_used_i,
    input  wire logic        local_cmd_i,
    input  wire logic        local_permit_i,
    input  wire logic        remote_permit_i,
    input  wire logic        operator_command_channel_i,
    input  wire logic        operator_command_value_i,
    input  wire logic        open_permit_i,
    input  wire logic        close_permit_i,
    input  wire logic        synchronism_ok_i,
    input  wire logic        block_operation_i,
    input  wire logic        counter_reset_i,
    input  wire logic        open_pulse_out_o,
    input  wire logic        close_pulse_out_o,
    input  wire logic        sync_switch_start_o,
    input  wire logic        operation_o,
    input  wire logic        closed_ind_o,
    input  wire logic        open_ind_o,
    input  wire logic [31:0] op_count_o,
    input  wire logic [1:0]  state_o,
    input  wire logic        state_event_o
);
    // ==========================================================
    // Helpers
    // ==========================================================
    // Sync wait state is invisible here, so sync use is excluded
    wire logic src_ok = local_cmd_i ? local_permit_i : remote_permit_i;
    wire logic idle = !open_pulse_out_o && !close_pulse_out_o;
    wire logic req = operator_command_channel_i && src_ok && idle
                     && !block_operation_i && !sync_check_used_i;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // ==========================================================
    // Assertions
    // ==========================================================
    reset_outs_a: assert property ($rose(nrst_i) |->
        !operation_o && state_o == 2'h0 && op_count_o == 32'h0)
        else $error("outputs not clear after reset");
    open_cmd_a: assert property (
        req && !operator_command_value_i && open_permit_i
        |=> open_pulse_out_o) else $error("open request not answered");
    close_cmd_a: assert property (
        req && operator_command_value_i && close_permit_i
        && synchronism_ok_i |=> close_pulse_out_o)
        else $error("close request not answered");
    permit_gate_a: assert property ($rose(open_pulse_out_o) |->
        $past(open_permit_i) && $past(operator_command_channel_i))
        else $error("open pulse without permission");
    block_cmd_a: assert property (block_operation_i[*3] |->
        !open_pulse_out_o && !close_pulse_out_o)
        else $error("command while blocked");
    cnt_step_a: assert property ($changed(op_count_o)
        && !$past(counter_reset_i) && !$past(counter_reset_i, 2)
        |-> op_count_o == $past(op_count_o) + 32'h1)
        else $error("counter step not one");
    cnt_clear_a: assert property (counter_reset_i |->
        ##[1:2] op_count_o <= 32'h1) else $error("counter not cleared");
    state_evt_a: assert property ($changed(state_o) |->
        state_event_o) else $error("state change without event");
    evt_cause_a: assert property (state_event_o |->
        state_o != $past(state_o))
        else $error("event without state change");
    ind_excl_a: assert property (!(open_ind_o && closed_ind_o))
        else $error("both indications set");
    oper_start_a: assert property ($changed(state_o)
        && state_o == bco_pkg::BCO_ST_CLOSED
        && $past(state_o) == bco_pkg::BCO_ST_OPEN |-> ##[0:3] operation_o)
        else $error("operation missing on switching");
    oper_hold_a: assert property ($rose(operation_o) |=>
        operation_o[*8]) else $error("operation pulse cut short");
    sync_one_a: assert property (sync_switch_start_o |=>
        !sync_switch_start_o) else $error("sync start not one cycle");
    open_c: cover property ($rose(open_pulse_out_o));
    close_c: cover property ($rose(close_pulse_out_o));
    oper_c: cover property ($rose(operation_o));
    evt_c: cover property (state_event_o);
endmodule : bco_breaker_ctrl_assertions
`default_nettype wire

// [sim/bco_breaker_model.sv]
// Behavioural breaker drive with position contacts
`timescale 1ns/10ps
`default_nettype none
module bco_breaker_model (
    input  wire logic       clk_i,
    input  wire logic       open_cmd_i,
    input  wire logic       close_cmd_i,
    input  wire logic       bump_i,
    input  wire logic [3:0] delay_i,
    output logic            pos_open_o,
    output logic            pos_closed_o
);
    logic [3:0] hold = 4'h0;
    logic [1:0] travel = 2'h0;
    logic       tgt = 1'b0;
    initial begin
        pos_open_o = 1'b1;
        pos_closed_o = 1'b0;
    end
    // Contacts pass through mid travel; delay below 4'hF only
    always @(posedge clk_i) begin
        if (bump_i || (hold == delay_i && (open_cmd_i || close_cmd_i))) begin
            tgt <= bump_i ? pos_open_o : close_cmd_i;
            travel <= 2'h2;
            {pos_open_o, pos_closed_o} <= 2'h0;
        end else if (travel != 2'h0) begin
            travel <= travel - 2'h1;
            if (travel == 2'h1) begin
                {pos_open_o, pos_closed_o} <= {!tgt, tgt};
            end
        end
        hold <= (open_cmd_i || close_cmd_i) ?
                hold + {3'h0, hold != 4'hF} : 4'h0;
    end
endmodule : bco_breaker_model
`default_nettype wire

// [sim/bco_breaker_ctrl_tb.sv]
// Self-checking bench for the breaker command block
`timescale 1ns/10ps
`default_nettype none
module bco_breaker_ctrl_tb;
    logic        core_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [15:0] pulse_ms = 16'h012C;
    logic        lcmd = 1'b1, lperm = 1'b0, rperm = 1'b0, blk = 1'b0;
    logic        chan = 1'b0, cval = 1'b0, operm = 1'b0, cperm = 1'b0;
    logic        crst = 1'b0, bump = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0]  dly = 4'h1;
    logic [1:0]  addr = 2'h0;
    logic [7:0]  wdata = 8'h00;
    logic [31:0] seed = 32'h9F5C3721;
    logic        pos_o, pos_c, irq, opo, clo, ssw, oper, unint, cind, oind;
    logic        sev;
    logic [31:0] rdata, cnt;
    logic [1:0]  st;
    int          n_mismatch = 0, compares = 0, cyc = 0, n_ev = 0;
    always #2.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (sev === 1'b1) begin
            n_ev <= n_ev + 1;
        end
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [1:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        {addr, rd} <= {a, 1'b1};
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rreg
    task automatic cmd(input logic v);
        @(posedge core_clk_i);
        {chan, cval} <= {1'b1, v};
        @(posedge core_clk_i);
        chan <= 1'b0;
        tick(1);
    endtask : cmd
    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        repeat (8) @(posedge core_clk_i);
        seed = xs(seed);
        nrst_i <= 1'b1;
        pulse_ms <= 16'h0032 + {7'h0, seed[8:0]};
        tick(20);
        chk(st, 32'h1);
        chk({cind, oind}, 32'h1);
        chk(cnt, 32'h0);
        chk(n_ev, 32'h1);
        seed = xs(seed);
        wreg(2'h1, seed[7:0]);
        rreg(2'h1, {28'h0, seed[3:0]});
        wreg(2'h0, 8'hFF);
        rreg(2'h0, 32'h1);
        rreg(2'h2, 32'h0);
        wreg(2'h1, 8'h00);
        tick(2);
        chk(irq, 32'h0);
        wreg(2'h1, 8'h0F);
        tick(2);
        chk(irq, 32'h1);
        wreg(2'h2, 8'h0F);
        tick(2);
        chk(irq, 32'h0);
        {lperm, operm} <= 2'h3;
        cmd(1'b1);
        chk({opo, clo}, 32'h0);
        {blk, cperm} <= 2'h3;
        cmd(1'b0);
        chk({opo, clo}, 32'h0);
        {blk, lcmd} <= 2'h0;
        cmd(1'b0);
        chk({opo, clo}, 32'h0);
        bump <= 1'b1;
        @(posedge core_clk_i);
        bump <= 1'b0;
        tick(30);
        chk({cind, oind}, 32'h2);
        chk(st, 32'h2);
        chk(oper, 32'h1);
        chk(unint, 32'h1);
        chk(n_ev, 32'h2);
        rreg(2'h3, 32'h1);
        rreg(2'h0, 32'h7);
        chk(irq, 32'h1);
        crst <= 1'b1;
        @(posedge core_clk_i);
        crst <= 1'b0;
        tick(3);
        chk(cnt, 32'h0);
        seed = xs(seed);
        {lcmd, dly} <= {1'b1, 1'b0, seed[2:0]};
        cmd(1'b0);
        chk({opo, clo}, 32'h2);
        tick(40);
        chk({cind, oind}, 32'h1);
        chk(unint, 32'h0);
        chk(opo, 32'h1);
        chk(cnt, 32'h0);
        blk <= 1'b1;
        tick(4);
        chk(opo, 32'h0);
        {blk, dly} <= {1'b0, 4'h9};
        cmd(1'b1);
        chk({opo, clo}, 32'h1);
        tick(40);
        chk({cind, oind}, 32'h2);
        chk(n_ev, 32'h4);
        chk(clo, 32'h1);
        blk <= 1'b1;
        tick(4);
        chk(clo, 32'h0);
        tally_and_finish();
    end
    bco_breaker_model bco_breaker_model_i (
        .clk_i        (core_clk_i),
        .open_cmd_i   (opo),
        .close_cmd_i  (clo),
        .bump_i       (bump),
        .delay_i      (dly),
        .pos_open_o   (pos_o),
        .pos_closed_o (pos_c)
    );
    bco_breaker_ctrl bco_breaker_ctrl_i (
        .core_clk_i (core_clk_i), .nrst_i (nrst_i),
        .pulse_ms_i (pulse_ms), .synchk_ms_i (16'h000A),
        .interm_ms_i (16'h0001), .sync_check_used_i (1'b0),
        .local_cmd_i (lcmd), .local_permit_i (lperm),
        .remote_permit_i (rperm), .operator_command_channel_i (chan),
        .operator_command_value_i (cval), .open_permit_i (operm),
        .close_permit_i (cperm), .synchronism_ok_i (1'b1),
        .block_operation_i (blk), .counter_reset_i (crst),
        .position_open_in_i (pos_o), .position_closed_in_i (pos_c),
        .external_command_seen_i (1'b0), .addr_i (addr),
        .wdata_i (wdata), .wr_i (wr), .rd_i (rd), .rdata_o (rdata),
        .irq_o (irq), .open_pulse_out_o (opo), .close_pulse_out_o (clo),
        .sync_switch_start_o (ssw), .operation_o (oper),
        .unintended_operation_o (unint), .closed_ind_o (cind),
        .open_ind_o (oind), .op_count_o (cnt), .state_o (st),
        .state_event_o (sev)
    );
endmodule : bco_breaker_ctrl_tb
bind bco_breaker_ctrl bco_breaker_ctrl_assertions chk_i (
    .core_clk_i (core_clk_i), .nrst_i (nrst_i),
    .sync_check_used_i (sync_check_used_i), .local_cmd_i (local_cmd_i),
    .local_permit_i (local_permit_i), .remote_permit_i (remote_permit_i),
    .operator_command_channel_i (operator_command_channel_i),
    .operator_command_value_i (operator_command_value_i),
    .open_permit_i (open_permit_i), .close_permit_i (close_permit_i),
    .synchronism_ok_i (synchronism_ok_i),
    .block_operation_i (block_operation_i),
    .counter_reset_i (counter_reset_i),
    .open_pulse_out_o (open_pulse_out_o),
    .close_pulse_out_o (close_pulse_out_o),
    .sync_switch_start_o (sync_switch_start_o), .operation_o (operation_o),
    .closed_ind_o (closed_ind_o), .open_ind_o (open_ind_o),
    .op_count_o (op_count_o), .state_o (state_o),
    .state_event_o (state_event_o)
);
`default_nettype wire
